// >>> shift_swap_pkg.sv
// Constants shared by the shift, rotate and nibble-swap unit.
// Assumes a single core clock and a 32-bit APB register window.
package shift_swap_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WORK  = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_CMD   = 8'h08;
  localparam logic [7:0] OFS_MADDR = 8'h0c;
  localparam logic [7:0] OFS_MDATA = 8'h10;

  // ----------------------------------------------------------------
  // Flag and command bit positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLG_CARRY = 0;
  localparam int unsigned FLG_ZERO  = 1;
  localparam int unsigned FLG_HALF  = 2;
  localparam int unsigned FLG_RANGE = 3;
  localparam int unsigned CMD_BUSY  = 8;
  localparam logic [7:0] WORK_RST  = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [3:0] OP_RST    = 4'h0;

  // ----------------------------------------------------------------
  // Operation codes, bit 2 marks a memory operand
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SRZ_W = 4'h0;
  localparam logic [3:0] OP_RRC_W = 4'h1;
  localparam logic [3:0] OP_SLZ_W = 4'h2;
  localparam logic [3:0] OP_RLC_W = 4'h3;
  localparam logic [3:0] OP_SRZ_M = 4'h4;
  localparam logic [3:0] OP_RRC_M = 4'h5;
  localparam logic [3:0] OP_SLZ_M = 4'h6;
  localparam logic [3:0] OP_RLC_M = 4'h7;
  localparam logic [3:0] OP_SWAP_W = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } rmw_state_e;

endpackage

// >>> shift_swap_unit.sv
// Shift and rotate-through-carry on a working byte or memory byte; nibble swap on the working byte only.
// Assumes an APB master on REF_CLK; memory operands live in a local array.
//
// Register access over APB and the register addresses were chosen for this implementation.

// Operation
// - Shift working byte right, zero into bit 7, old bit 0 to carry
// - Rotate working byte right, old carry into bit 7, old bit 0 to carry
// - Shift memory byte right, zero into bit 7, old bit 0 to carry
// - Rotate memory byte right through carry, old bit 0 to carry
// - Shift working byte left, zero into bit 0, old bit 7 to carry
// - Rotate working byte left, old carry into bit 0, old bit 7 to carry
// - Shift memory byte left, zero into bit 0, old bit 7 to carry
// - Rotate memory byte left through carry, old bit 7 to carry
// - Swap high and low nibbles of the working byte
// - Shifts and rotates change only carry; other flags stay unchanged
module shift_swap_unit #(
  parameter int unsigned MEM_DEPTH = 16
) (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  import shift_swap_pkg::*;

  localparam int unsigned AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  // ----------------------------------------------------------------
  // Operation function: returns {carry, result}
  // ----------------------------------------------------------------
  function automatic logic [8:0] shift_op(input logic [3:0] op, input logic [7:0] v, input logic c);
    logic [8:0] r;
    r = {c, v};
    if (op == OP_SWAP_W) begin
      r = {c, v[3:0], v[7:4]};
    end else begin
      case (op[1:0])
        2'b00: r = {v[0], 1'b0, v[7:1]};
        2'b01: r = {v[0], c, v[7:1]};
        2'b10: r = {v[7], v[6:0], 1'b0};
        default: r = {v[7], v[6:0], c};
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]     work_q, work_d;
  logic [3:0]     flags_q, flags_d;
  logic [3:0]     op_q;
  logic [AW-1:0]  maddr_q;
  logic [7:0]     operand_q;
  logic [7:0]     mem_q [MEM_DEPTH];
  logic [31:0]    prdata_q;
  logic           rd_done_q;
  rmw_state_e     state_q, state_d;
  logic [31:0]    rd_mux;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire         busy       = (state_q != ST_IDLE);
  wire         apb_access = PSEL & PENABLE;
  wire         wr_en      = apb_access & PWRITE & ~busy;
  wire         rd_take    = apb_access & ~PWRITE & ~busy & ~rd_done_q;
  wire         hit_work   = (PADDR == OFS_WORK);
  wire         hit_flags  = (PADDR == OFS_FLAGS);
  wire         hit_cmd    = (PADDR == OFS_CMD);
  wire         hit_maddr  = (PADDR == OFS_MADDR);
  wire         hit_mdata  = (PADDR == OFS_MDATA);
  wire         hit_any    = hit_work | hit_flags | hit_cmd | hit_maddr | hit_mdata;
  wire [3:0]   cmd_op     = PWDATA[3:0];
  wire         cmd_valid  = (cmd_op <= OP_SWAP_W);
  wire         cmd_go     = wr_en & hit_cmd & cmd_valid;
  wire         mem_go     = cmd_go & (cmd_op[3:2] == 2'b01);
  wire         work_go    = cmd_go & ~mem_go;
  wire [8:0]   work_res   = shift_op(cmd_op, work_q, flags_q[FLG_CARRY]);
  wire [8:0]   mem_res    = shift_op(op_q, operand_q, flags_q[FLG_CARRY]);
  wire         mem_wb     = (state_q == ST_WRITE);

  assign PREADY  = ~busy & (PWRITE | rd_done_q);
  assign PSLVERR = apb_access & PREADY & ~hit_any;
  assign PRDATA  = prdata_q;

  always_comb begin
    if (hit_work) begin
      rd_mux = {24'h000000, work_q};
    end else if (hit_flags) begin
      rd_mux = {28'h0000000, flags_q};
    end else if (hit_cmd) begin
      rd_mux = {23'h000000, busy, 4'h0, op_q};
    end else if (hit_maddr) begin
      rd_mux = 32'(maddr_q);
    end else if (hit_mdata) begin
      rd_mux = {24'h000000, mem_q[maddr_q]};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    work_d = work_q;
    if (wr_en && hit_work) begin
      work_d = PWDATA[7:0];
    end else if (work_go) begin
      work_d = work_res[7:0];
    end
  end

  always_comb begin
    flags_d = flags_q;
    if (wr_en && hit_flags) begin
      flags_d = PWDATA[3:0];
    end else if (work_go && cmd_op != OP_SWAP_W) begin
      flags_d[FLG_CARRY] = work_res[8];
    end else if (mem_wb) begin
      flags_d[FLG_CARRY] = mem_res[8];
    end
  end

  always_comb begin
    case (state_q)
      ST_IDLE:  state_d = mem_go ? ST_READ : ST_IDLE;
      ST_READ:  state_d = ST_WRITE;
      ST_WRITE: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      work_q  <= WORK_RST;
      flags_q <= FLAGS_RST;
      state_q <= ST_IDLE;
    end else begin
      work_q  <= work_d;
      flags_q <= flags_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      op_q    <= OP_RST;
      maddr_q <= '0;
    end else begin
      if (cmd_go) op_q <= cmd_op;
      if (wr_en && hit_maddr) maddr_q <= PWDATA[AW-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      prdata_q  <= 32'h00000000;
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= rd_take;
      if (rd_take) prdata_q <= rd_mux;
    end
  end

  // Memory read-modify-write on the same address
  always_ff @(posedge REF_CLK) begin
    if (state_q == ST_READ) operand_q <= mem_q[maddr_q];
    if (mem_wb) begin
      mem_q[maddr_q] <= mem_res[7:0];
    end else if (wr_en && hit_mdata) begin
      mem_q[maddr_q] <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  chk_srz_work: assert property (
    (work_go && cmd_op == OP_SRZ_W) |=> (work_q == {1'b0, $past(work_q[7:1])})
      && (flags_q[FLG_CARRY] == $past(work_q[0])))
    else $error("right zero-fill shift of working byte wrong");

  chk_rrc_work: assert property (
    (work_go && cmd_op == OP_RRC_W) |=> (work_q == {$past(flags_q[FLG_CARRY]), $past(work_q[7:1])})
      && (flags_q[FLG_CARRY] == $past(work_q[0])))
    else $error("right rotate of working byte wrong");

  chk_srz_mem: assert property (
    (mem_go && cmd_op == OP_SRZ_M) |-> ##3 (mem_q[maddr_q] == {1'b0, $past(mem_q[maddr_q][7:1], 3)})
      && (flags_q[FLG_CARRY] == $past(mem_q[maddr_q][0], 3)))
    else $error("right zero-fill shift of memory byte wrong");

  chk_rrc_mem: assert property (
    (mem_go && cmd_op == OP_RRC_M) |-> ##3
      (mem_q[maddr_q] == {$past(flags_q[FLG_CARRY], 3), $past(mem_q[maddr_q][7:1], 3)})
      && (flags_q[FLG_CARRY] == $past(mem_q[maddr_q][0], 3)))
    else $error("right rotate of memory byte wrong");

  chk_slz_work: assert property (
    (work_go && cmd_op == OP_SLZ_W) |=> (work_q == {$past(work_q[6:0]), 1'b0})
      && (flags_q[FLG_CARRY] == $past(work_q[7])))
    else $error("left zero-fill shift of working byte wrong");

  chk_rlc_work: assert property (
    (work_go && cmd_op == OP_RLC_W) |=> (work_q == {$past(work_q[6:0]), $past(flags_q[FLG_CARRY])})
      && (flags_q[FLG_CARRY] == $past(work_q[7])))
    else $error("left rotate of working byte wrong");

  chk_slz_mem: assert property (
    (mem_go && cmd_op == OP_SLZ_M) |-> ##3 (mem_q[maddr_q] == {$past(mem_q[maddr_q][6:0], 3), 1'b0})
      && (flags_q[FLG_CARRY] == $past(mem_q[maddr_q][7], 3)))
    else $error("left zero-fill shift of memory byte wrong");

  chk_rlc_mem: assert property (
    (mem_go && cmd_op == OP_RLC_M) |-> ##3
      (mem_q[maddr_q] == {$past(mem_q[maddr_q][6:0], 3), $past(flags_q[FLG_CARRY], 3)})
      && (flags_q[FLG_CARRY] == $past(mem_q[maddr_q][7], 3)))
    else $error("left rotate of memory byte wrong");

  chk_nibble_swap: assert property (
    (work_go && cmd_op == OP_SWAP_W) |=> (work_q == {$past(work_q[3:0]), $past(work_q[7:4])})
      && $stable(flags_q))
    else $error("nibble swap wrong");

  chk_other_flags: assert property (
    (busy || work_go) |=> $stable(flags_q[FLG_RANGE:FLG_ZERO]))
    else $error("non-carry flag changed by an operation");

  chk_mem_keeps_work: assert property (
    mem_go |=> $stable(work_q) [*3] ##0 (state_q == ST_IDLE))
    else $error("memory operation disturbed working byte or overran");

endmodule

// >>> shift_swap_unit_bench.sv
// Self-checking bench for the shift, rotate and nibble-swap unit.
// Assumes the package constants and an APB slave that answers through PREADY.
module shift_swap_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import shift_swap_pkg::*;

  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          seed     = 62689;

  always #10 ref_clk = ~ref_clk;

  shift_swap_unit #(.MEM_DEPTH(16)) shift_swap_unit_inst (
    .REF_CLK (ref_clk),
    .RST_N   (rst_n),
    .PSEL    (psel),
    .PENABLE (penable),
    .PWRITE  (pwrite),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns one edge after the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      $display("ERROR pready expected 1 seen timeout");
      results();
    end else begin
      r       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, exp, r);
    chk("slverr", 32'h0, {31'h0, e});
  endtask

  // Carry out in bit 8, result byte below it
  function automatic logic [8:0] expect_op(input logic [3:0] op, input logic [7:0] v, input logic c);
    if (op == OP_SWAP_W) return {c, v[3:0], v[7:4]};
    case (op[1:0])
      2'h0: return {v[0], 1'b0, v[7:1]};
      2'h1: return {v[0], c, v[7:1]};
      2'h2: return {v[7], v[6:0], 1'b0};
      default: return {v[7], v[6:0], c};
    endcase
  endfunction

  task automatic run_op(input logic [3:0] op, input logic [7:0] w, input logic [7:0] m,
                        input logic [3:0] f, input logic [3:0] a);
    logic [8:0] res;
    logic       mem_op;
    res    = expect_op(op, (op[2] && op != OP_SWAP_W) ? m : w, f[FLG_CARRY]);
    mem_op = op[2] && (op != OP_SWAP_W);
    wr(OFS_WORK, {24'h0, w});
    wr(OFS_FLAGS, {28'h0, f});
    wr(OFS_MADDR, {28'h0, a});
    wr(OFS_MDATA, {24'h0, m});
    wr(OFS_CMD, {28'h0, op});
    rd_chk("work", OFS_WORK, {24'h0, mem_op ? w : res[7:0]});
    rd_chk("mdata", OFS_MDATA, {24'h0, mem_op ? res[7:0] : m});
    rd_chk("flags", OFS_FLAGS, {28'h0, f[3:1], (op == OP_SWAP_W) ? f[0] : res[8]});
    wr(OFS_CMD, 32'h0000_0009);
    rd_chk("cmd", OFS_CMD, {28'h0, op});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("work reset", OFS_WORK, {24'h0, WORK_RST});
    rd_chk("flags reset", OFS_FLAGS, {28'h0, FLAGS_RST});
    rd_chk("cmd reset", OFS_CMD, {28'h0, OP_RST});
    rd_chk("maddr reset", OFS_MADDR, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped data", 32'h0, r);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, 8'h14, 32'hffff_ffff, r, e);
    chk("unmapped wr err", 32'h1, {31'h0, e});
    rd_chk("work after unmapped wr", OFS_WORK, {24'h0, WORK_RST});
    $display("test reset and map done");
    for (int op = 0; op < 9; op++) begin
      run_op(op[3:0], 8'h81, 8'h7e, 4'he, op[3:0]);
      run_op(op[3:0], 8'h7e, 8'h81, 4'h1, 4'hf - op[3:0]);
    end
    $display("test corner patterns done");
    for (int i = 0; i < 60; i++) begin
      run_op(4'($unsigned($random(seed)) % 9), 8'($random(seed)), 8'($random(seed)),
             4'($random(seed)), 4'($random(seed)));
    end
    $display("test random ops done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("work rereset", OFS_WORK, {24'h0, WORK_RST});
    rd_chk("flags rereset", OFS_FLAGS, {28'h0, FLAGS_RST});
    rd_chk("cmd rereset", OFS_CMD, {28'h0, OP_RST});
    rd_chk("maddr rereset", OFS_MADDR, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule
